/* File: logic/eag_defines.svh */
// Constants for the effective address generator
`ifndef EAG_DEFINES_SVH
`define EAG_DEFINES_SVH
`define EAG_LEN1 16'h0001
`define EAG_LEN2 16'h0002
`define EAG_LEN3 16'h0003
`define EAG_ZERO_PAGE 8'h00
`define EAG_HI_NIB 7:4
`define EAG_BIT_SEL 3:1
`define EAG_POL_BIT 0
`define EAG_GRP_BTB 4'h0
`define EAG_GRP_BSC 4'h1
`define EAG_GRP_REL 4'h2
`define EAG_GRP_DIR_RMW 4'h3
`define EAG_GRP_IX_RMW 4'h7
`define EAG_GRP_IX1_RMW 4'h6
`define EAG_GRP_INH_LO 4'h4
`define EAG_GRP_INH_HI 4'h5
`define EAG_GRP_INH_C1 4'h8
`define EAG_GRP_INH_C2 4'h9
`define EAG_GRP_IMM 4'ha
`define EAG_GRP_DIR 4'hb
`define EAG_GRP_EXT 4'hc
`define EAG_GRP_IX2 4'hd
`define EAG_GRP_IX1 4'he
`define EAG_GRP_IX 4'hf
`endif

/* File: logic/eag_pkg.sv */
// Types for the effective address generator
package eag_pkg;
  typedef enum logic [3:0] {
    EAG_MODE_INH = 4'h0,
    EAG_MODE_IMM = 4'h1,
    EAG_MODE_DIR = 4'h2,
    EAG_MODE_EXT = 4'h3,
    EAG_MODE_IX = 4'h4,
    EAG_MODE_IX1 = 4'h5,
    EAG_MODE_IX2 = 4'h6,
    EAG_MODE_REL = 4'h7,
    EAG_MODE_BSC = 4'h8,
    EAG_MODE_BTB = 4'h9
  } eag_mode_t;
endpackage : eag_pkg

/* File: logic/eag_mode_decode.sv */
// Opcode to addressing mode decoder
`timescale 1ns/1ps
`include "eag_defines.svh"
module eag_mode_decode (
  input wire logic [7:0] opcode,
  output eag_pkg::eag_mode_t mode
);
  // Mode follows the high nibble of the opcode map
  always_comb begin
    unique case (opcode[`EAG_HI_NIB])
      `EAG_GRP_BTB: mode = eag_pkg::EAG_MODE_BTB;
      `EAG_GRP_BSC: mode = eag_pkg::EAG_MODE_BSC;
      `EAG_GRP_REL: mode = eag_pkg::EAG_MODE_REL;
      `EAG_GRP_DIR_RMW, `EAG_GRP_DIR: mode = eag_pkg::EAG_MODE_DIR;
      `EAG_GRP_IX1_RMW, `EAG_GRP_IX1: mode = eag_pkg::EAG_MODE_IX1;
      `EAG_GRP_IX_RMW, `EAG_GRP_IX: mode = eag_pkg::EAG_MODE_IX;
      `EAG_GRP_IMM: mode = eag_pkg::EAG_MODE_IMM;
      `EAG_GRP_EXT: mode = eag_pkg::EAG_MODE_EXT;
      `EAG_GRP_IX2: mode = eag_pkg::EAG_MODE_IX2;
      default: mode = eag_pkg::EAG_MODE_INH; // 4,5,8,9 inherent
    endcase
  end
endmodule : eag_mode_decode

/* File: logic/eag_branch_add.sv */
// Signed byte offset added to a 16-bit base, wrapping
`timescale 1ns/1ps
module eag_branch_add (
  input wire logic [15:0] base,
  input wire logic [7:0] offset,
  output logic [15:0] target
);
  assign target = base + {{8{offset[7]}}, offset};
endmodule : eag_branch_add

/* File: logic/eag_top.sv */
// Effective address and next program counter generator
`timescale 1ns/1ps
`include "eag_defines.svh"
module eag_top #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned BYTE_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic [BYTE_W-1:0] opcode,
  input wire logic [BYTE_W-1:0] byte1,
  input wire logic [BYTE_W-1:0] byte2,
  input wire logic [BYTE_W-1:0] index_x,
  input wire logic branch_cond,
  input wire logic [BYTE_W-1:0] test_data,
  output logic [BYTE_W-1:0] addr_hi_q,
  output logic [BYTE_W-1:0] addr_lo_q,
  output logic [ADDR_W-1:0] operand_address_q,
  output logic [ADDR_W-1:0] next_pc_q,
  output logic carry_load_q,
  output logic carry_value_q,
  output logic [2:0] bit_number_q,
  output logic [3:0] mode_q
);
  eag_pkg::eag_mode_t mode;
  logic [15:0] rel_base;
  logic [15:0] btb_base;
  logic [15:0] rel_target;
  logic [15:0] btb_target;
  logic [8:0] ix1_sum;
  logic [8:0] ix2_lo;
  logic [7:0] ix2_hi;
  logic tested_bit;
  logic btb_pass;
  logic [15:0] addr_d;
  logic [15:0] pc_d;

  // Byte concatenations below serve only 8-bit bytes in a 16-bit space
  if (BYTE_W != 8 || ADDR_W != 16) begin : g_width_check
    $error("eag_top needs 8-bit bytes and 16-bit addresses");
  end

  eag_mode_decode u_dec (
    .opcode(opcode),
    .mode(mode)
  );

  // Next instruction addresses for the two branch kinds
  assign rel_base = pc + `EAG_LEN2;
  assign btb_base = pc + `EAG_LEN3;

  eag_branch_add u_rel (
    .base(rel_base),
    .offset(byte1),
    .target(rel_target)
  );

  eag_branch_add u_btb (
    .base(btb_base),
    .offset(byte2),
    .target(btb_target)
  );

  // Low index sums keep their carries; the IX2 high byte wraps
  assign ix1_sum = {1'b0, index_x} + {1'b0, byte1};
  assign ix2_lo = {1'b0, index_x} + {1'b0, byte2};
  assign ix2_hi = byte1 + {7'h00, ix2_lo[8]};

  // bit and polarity selected by opcode
  assign tested_bit = test_data[opcode[`EAG_BIT_SEL]];
  assign btb_pass = (tested_bit == ~opcode[`EAG_POL_BIT]);

  // Address and next pc per mode
  always_comb begin
    addr_d = 16'h0000;
    pc_d = pc + `EAG_LEN1;
    unique case (mode)
      eag_pkg::EAG_MODE_IMM: begin
        addr_d = pc + `EAG_LEN1;
        pc_d = pc + `EAG_LEN2;
      end
      eag_pkg::EAG_MODE_DIR: begin
        addr_d = {`EAG_ZERO_PAGE, byte1};
        pc_d = pc + `EAG_LEN2;
      end
      eag_pkg::EAG_MODE_EXT: begin
        addr_d = {byte1, byte2};
        pc_d = pc + `EAG_LEN3;
      end
      eag_pkg::EAG_MODE_IX: begin
        addr_d = {`EAG_ZERO_PAGE, index_x};
        pc_d = pc + `EAG_LEN1;
      end
      eag_pkg::EAG_MODE_IX1: begin
        addr_d = {7'h00, ix1_sum};
        pc_d = pc + `EAG_LEN2;
      end
      eag_pkg::EAG_MODE_IX2: begin
        addr_d = {ix2_hi, ix2_lo[7:0]};
        pc_d = pc + `EAG_LEN3;
      end
      eag_pkg::EAG_MODE_REL: begin
        addr_d = branch_cond ? rel_target : rel_base;
        pc_d = branch_cond ? rel_target : rel_base;
      end
      eag_pkg::EAG_MODE_BSC: begin
        addr_d = {`EAG_ZERO_PAGE, byte1};
        pc_d = pc + `EAG_LEN2;
      end
      eag_pkg::EAG_MODE_BTB: begin
        addr_d = {`EAG_ZERO_PAGE, byte1};
        pc_d = btb_pass ? btb_target : btb_base;
      end
      eag_pkg::EAG_MODE_INH: begin
        addr_d = 16'h0000;
        pc_d = pc + `EAG_LEN1;
      end
    endcase
  end

  // Address bus and pc registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operand_address_q <= 16'h0000;
      addr_hi_q <= 8'h00;
      addr_lo_q <= 8'h00;
      next_pc_q <= 16'h0000;
      mode_q <= 4'h0;
    end else begin
      operand_address_q <= addr_d;
      addr_hi_q <= addr_d[15:8];
      addr_lo_q <= addr_d[7:0];
      next_pc_q <= pc_d;
      mode_q <= mode;
    end
  end

  // Carry and bit-number outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_load_q <= 1'b0;
      carry_value_q <= 1'b0;
      bit_number_q <= 3'h0;
    end else begin
      // copy tested bit whether taken or not
      carry_load_q <= (mode == eag_pkg::EAG_MODE_BTB);
      carry_value_q <= tested_bit;
      bit_number_q <= opcode[`EAG_BIT_SEL];
    end
  end

  // Reference target for the checks
  logic [15:0] chk_rel;
  logic [15:0] chk_btb;
  logic [15:0] chk_ix2;
  assign chk_rel = pc + `EAG_LEN2 + {{8{byte1[7]}}, byte1};
  assign chk_btb = pc + `EAG_LEN3 + {{8{byte2[7]}}, byte2};
  assign chk_ix2 = {byte1, byte2} + {`EAG_ZERO_PAGE, index_x};

  a_ext_addr: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_EXT) |=> (operand_address_q == {$past(byte1), $past(byte2)})
      && (next_pc_q == $past(pc) + 16'h0003))
    else $error("extended address wrong");
  a_ix_zero: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX) |=> (addr_hi_q == 8'h00) && (addr_lo_q == $past(index_x))
      && (next_pc_q == $past(pc) + 16'h0001))
    else $error("indexed no offset wrong");
  a_ix1_sum: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX1) |=> (operand_address_q == {8'h00, $past(index_x)} + {8'h00, $past(byte1)})
      && (operand_address_q <= 16'h01fe))
    else $error("indexed 8-bit offset wrong");
  a_ix2_sum: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX2) |=> (operand_address_q == $past(chk_ix2))
      && (next_pc_q == $past(pc) + 16'h0003))
    else $error("indexed 16-bit offset wrong");
  a_rel_branch: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_REL) |=> next_pc_q == ($past(branch_cond) ? $past(chk_rel) : $past(pc) + 16'h0002))
    else $error("relative branch pc wrong");
  a_rel_span: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_REL && branch_cond) |=>
      (16'(next_pc_q - $past(pc) + 16'h007e) <= 16'h00ff))
    else $error("relative span exceeded");
  a_bsc_page0: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BSC) |=> (addr_hi_q == 8'h00) && (bit_number_q == $past(opcode[3:1])))
    else $error("bit set/clear address wrong");
  a_btb_carry: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) |=> carry_load_q && (carry_value_q == $past(test_data[opcode[3:1]])))
    else $error("carry not copied");
  a_btb_pc: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) |=> next_pc_q == ($past(btb_pass) ? $past(chk_btb) : $past(pc) + 16'h0003))
    else $error("bit test branch pc wrong");
  a_dir_page0: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_DIR) |=> (operand_address_q == {8'h00, $past(byte1)}))
    else $error("direct address wrong");
  a_imm_addr: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IMM) |=> (operand_address_q == $past(pc) + 16'h0001))
    else $error("immediate address wrong");

  // Each bus byte carries its own half, not just the joined word
  a_ext_bytes: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_EXT) |=>
      (addr_hi_q == $past(byte1)) && (addr_lo_q == $past(byte2)))
    else $error("extended bus bytes wrong");

  // A pc near the top of memory must land near the bottom
  a_ext_wrap: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_EXT) && (pc >= 16'hfffd) |=>
      (next_pc_q <= `EAG_LEN2))
    else $error("pc did not wrap");

  // Index alone, never above page zero
  a_ix_bus: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX) |=>
      (operand_address_q == {`EAG_ZERO_PAGE, $past(index_x)}))
    else $error("indexed address not in page zero");

  // Carry of the byte sum is the whole high byte
  a_ix1_high: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX1) |=>
      (addr_hi_q == {7'h00, ($past(index_x) > ~$past(byte1))}))
    else $error("indexed 8-bit carry wrong");

  // Low byte and pc step for the short offset
  a_ix1_pc: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX1) |=>
      (next_pc_q == $past(pc) + `EAG_LEN2) && (addr_lo_q == 8'($past(index_x) + $past(byte1))))
    else $error("indexed 8-bit low byte or pc wrong");

  // Carry from the low sum moves into the first offset byte
  a_ix2_high: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IX2) |=>
      (addr_hi_q == 8'($past(byte1) + ($past(index_x) > ~$past(byte2)))) && (addr_lo_q == 8'($past(index_x) + $past(byte2))))
    else $error("indexed 16-bit bytes wrong");

  // Direct is a two-byte instruction in page zero
  a_dir_pc: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_DIR) |=>
      (next_pc_q == $past(pc) + `EAG_LEN2) && (addr_hi_q == `EAG_ZERO_PAGE))
    else $error("direct pc or high byte wrong");

  // Immediate skips its one operand byte
  a_imm_pc: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_IMM) |=>
      (next_pc_q == $past(pc) + `EAG_LEN2))
    else $error("immediate pc wrong");

  // An untaken branch only steps over itself
  a_rel_fall: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_REL) && !branch_cond |=>
      (next_pc_q == $past(pc) + `EAG_LEN2) && (operand_address_q == next_pc_q))
    else $error("untaken branch pc wrong");

  // Bit set or clear is two bytes long, target from the next byte
  a_bsc_pc: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BSC) |=>
      (next_pc_q == $past(pc) + `EAG_LEN2) && (addr_lo_q == $past(byte1)))
    else $error("bit set/clear pc or low byte wrong");

  // Test byte address and bit number from the instruction
  a_btb_addr: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) |=>
      (operand_address_q == {`EAG_ZERO_PAGE, $past(byte1)}) && (bit_number_q == $past(opcode[`EAG_BIT_SEL])))
    else $error("bit test address or bit wrong");

  // Test byte goes out on the bus halves as well
  a_btb_bus: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) |=>
      (addr_hi_q == `EAG_ZERO_PAGE) && (addr_lo_q == $past(byte1)))
    else $error("bit test bus bytes wrong");

  // Whole reachable window is 256 bytes wide around the opcode
  a_btb_span: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) |=>
      (16'(next_pc_q - $past(pc) + 16'h007d) <= 16'h00ff))
    else $error("bit test span exceeded");

  // Bit equal to the polarity bit means the test failed
  a_btb_fail: assert property (@(posedge clk) disable iff (rst)
    (mode == eag_pkg::EAG_MODE_BTB) && (test_data[opcode[`EAG_BIT_SEL]] == opcode[`EAG_POL_BIT]) |=>
      (next_pc_q == $past(pc) + `EAG_LEN3))
    else $error("failed bit test did not fall through");

  // Carry is only loaded by the bit test, so others leave it alone
  a_carry_idle: assert property (@(posedge clk) disable iff (rst)
    (mode != eag_pkg::EAG_MODE_BTB) |=>
      !carry_load_q)
    else $error("carry loaded outside bit test");
endmodule : eag_top

/* File: dv/eag_mem_model.sv */
// Page-zero memory model that answers the bit-test read
`timescale 1ns/1ps
module eag_mem_model (
  input wire logic [7:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];
  // Every byte differs, so a wrong test address shows up as a wrong bit
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end
  // Combinational read; the core samples it on the same edge as the opcode
  assign rdata = mem[addr];
endmodule : eag_mem_model

/* File: dv/tb_top.sv */
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] pc = 16'h0000;
  logic [7:0] opcode = 8'h00, byte1 = 8'h00, byte2 = 8'h00, index_x = 8'h00, test_data;
  logic branch_cond = 1'b0;
  logic [7:0] addr_hi_q, addr_lo_q;
  logic [15:0] operand_address_q, next_pc_q;
  logic carry_load_q, carry_value_q;
  logic [2:0] bit_number_q;
  logic [3:0] mode_q;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  eag_mem_model i_eag_mem_model (.addr(byte1), .rdata(test_data));
  eag_top i_eag_top (.clk(clk), .rst(rst), .pc(pc), .opcode(opcode), .byte1(byte1), .byte2(byte2),
    .index_x(index_x), .branch_cond(branch_cond), .test_data(test_data), .addr_hi_q(addr_hi_q),
    .addr_lo_q(addr_lo_q), .operand_address_q(operand_address_q), .next_pc_q(next_pc_q),
    .carry_load_q(carry_load_q), .carry_value_q(carry_value_q), .bit_number_q(bit_number_q), .mode_q(mode_q));
  task finish_test;
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // One instruction in, outputs settled one edge later
  task step(input logic [7:0] op, b1, b2, input logic [15:0] p, input logic [7:0] x, input logic c);
    @(posedge clk);
    opcode <= op; byte1 <= b1; byte2 <= b2; pc <= p; index_x <= x; branch_cond <= c;
    @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [15:0] ea, npc, input logic cl, input eag_pkg::eag_mode_t m);
    cmp(operand_address_q, ea, "address");
    cmp({addr_hi_q, addr_lo_q}, ea, "bus bytes");
    cmp(next_pc_q, npc, "next pc");
    cmp({15'h0000, carry_load_q}, {15'h0000, cl}, "carry load");
    cmp({12'h000, mode_q}, {12'h000, m}, "mode");
  endtask : chk
  // Every registered output reads zero while reset is held
  task t_reset;
    cmp(next_pc_q, 16'h0000, "pc in reset");
    cmp(operand_address_q, 16'h0000, "address in reset");
    cmp({addr_hi_q, addr_lo_q}, 16'h0000, "bus in reset");
    cmp({11'h000, carry_load_q, carry_value_q, bit_number_q}, 16'h0000, "carry in reset");
    cmp({12'h000, mode_q}, 16'h0000, "mode in reset");
  endtask : t_reset
  // Reset in mid-run clears at once, then work resumes
  task t_rst_mid;
    step(8'hc6, 8'h12, 8'h34, 16'h0100, 8'h55, 1'b0);
    chk(16'h1234, 16'h0103, 1'b0, eag_pkg::EAG_MODE_EXT);
    @(posedge clk);
    rst <= 1'b1;
    #1;
    t_reset();
    @(posedge clk);
    rst <= 1'b0;
    step(8'hd6, 8'h01, 8'hff, 16'h0500, 8'h02, 1'b0);
    chk(16'h0201, 16'h0503, 1'b0, eag_pkg::EAG_MODE_IX2);
  endtask : t_rst_mid
  task t_ext;
    step(8'hc6, 8'h12, 8'h34, 16'h0100, 8'h55, 1'b0);
    chk(16'h1234, 16'h0103, 1'b0, eag_pkg::EAG_MODE_EXT);
    step(8'hc6, 8'hff, 8'hfe, 16'hfffe, 8'h00, 1'b0);
    chk(16'hfffe, 16'h0001, 1'b0, eag_pkg::EAG_MODE_EXT);
  endtask : t_ext
  task t_index;
    step(8'hf6, 8'hab, 8'hcd, 16'h0200, 8'hff, 1'b0);
    chk(16'h00ff, 16'h0201, 1'b0, eag_pkg::EAG_MODE_IX);
    step(8'he6, 8'hff, 8'h00, 16'h0200, 8'hff, 1'b0);
    chk(16'h01fe, 16'h0202, 1'b0, eag_pkg::EAG_MODE_IX1);
    step(8'hd6, 8'h12, 8'hf0, 16'h0200, 8'h20, 1'b0);
    chk(16'h1310, 16'h0203, 1'b0, eag_pkg::EAG_MODE_IX2);
    step(8'hd6, 8'hff, 8'hff, 16'hfffd, 8'h01, 1'b0);
    chk(16'h0000, 16'h0000, 1'b0, eag_pkg::EAG_MODE_IX2);
  endtask : t_index
  task t_dir_imm;
    step(8'hb6, 8'h44, 8'h99, 16'h0300, 8'h11, 1'b0);
    chk(16'h0044, 16'h0302, 1'b0, eag_pkg::EAG_MODE_DIR);
    step(8'ha6, 8'h44, 8'h99, 16'h0300, 8'h11, 1'b0);
    chk(16'h0301, 16'h0302, 1'b0, eag_pkg::EAG_MODE_IMM);
    step(8'h4c, 8'h44, 8'h99, 16'h0300, 8'h11, 1'b1);
    chk(16'h0000, 16'h0301, 1'b0, eag_pkg::EAG_MODE_INH);
  endtask : t_dir_imm
  task t_rel;
    step(8'h20, 8'h7f, 8'h00, 16'h1000, 8'h00, 1'b1);
    chk(16'h1081, 16'h1081, 1'b0, eag_pkg::EAG_MODE_REL);
    step(8'h26, 8'h80, 8'h00, 16'h1000, 8'h00, 1'b1);
    chk(16'h0f82, 16'h0f82, 1'b0, eag_pkg::EAG_MODE_REL);
    step(8'h27, 8'h80, 8'h00, 16'h1000, 8'h00, 1'b0);
    chk(16'h1002, 16'h1002, 1'b0, eag_pkg::EAG_MODE_REL);
  endtask : t_rel
  task t_bsc;
    for (int k = 0; k < 16; k++) begin
      step(8'h10 + 8'(k), 8'(k * 13), 8'h77, 16'h0400, 8'h33, 1'b0);
      chk({8'h00, 8'(k * 13)}, 16'h0402, 1'b0, eag_pkg::EAG_MODE_BSC);
      cmp({13'h0000, bit_number_q}, 16'(k >> 1), "bit number");
    end
  endtask : t_bsc
  task t_btb;
    logic [7:0] b1, d;
    logic taken;
    logic [15:0] tgt;
    for (int k = 0; k < 16; k++) begin
      b1 = 8'(k * 17 + 3);
      step(8'(k), b1, k[1] ? 8'h80 : 8'h7f, 16'h2000, 8'h44, 1'b0);
      d = i_eag_mem_model.mem[b1];
      taken = d[k >> 1] ^ k[0];
      tgt = taken ? (k[1] ? 16'h2000 - 16'd125 : 16'h2000 + 16'd130) : 16'h2003;
      chk({8'h00, b1}, tgt, 1'b1, eag_pkg::EAG_MODE_BTB);
      cmp({15'h0000, carry_value_q}, {15'h0000, d[k >> 1]}, "carry value");
    end
  endtask : t_btb
  // Reset for three cycles, then every mode back to back
  initial begin
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rst <= 1'b0;
    t_ext();
    t_index();
    t_dir_imm();
    t_rel();
    t_bsc();
    t_btb();
    t_rst_mid();
    finish_test();
  end
endmodule : tb_top
